// >>> include/irp_defines.svh
/*
 * irp_defines.svh: register offsets, field masks, reset values and
 * status bit positions of the interrupt request/priority block.
 * assumes: included by bare name, before irp_pkg and the design.
 */
`ifndef IRP_DEFINES_SVH
`define IRP_DEFINES_SVH

// register offsets on the 12-bit register port
`define IRP_AW       12
`define IRP_OFS_G0EH 12'hfc1
`define IRP_OFS_G0EL 12'hfc2
`define IRP_OFS_G2RQ 12'hfc6
`define IRP_OFS_STAT 12'hfd0
`define IRP_OFS_MASK 12'hfd1

// group-0 source positions: timer1 6, timer0 5, rx 4, tx 3, converter 0
`define IRP_G0_SRC   8'h79
`define IRP_RST8     8'h00
`define IRP_RST4     4'h0
`define IRP_RST3     3'h0

// request sources: 8 group-0 slots, then 4 port C slots
`define IRP_NSRC     12
`define IRP_G2_BASE  8
`define IRP_G2_W     4

// status/mask bit positions
`define IRP_ST_W     3
`define IRP_ST_HWREQ 0
`define IRP_ST_ACK   1
`define IRP_ST_SWREQ 2

`endif

// >>> include/irp_pkg.sv
/*
 * irp_pkg: types of the interrupt request/priority block.
 * assumes: irp_defines.svh is available on the include path.
 */
`include "irp_defines.svh"

package irp_pkg;

    // two-bit enable pair decode
    typedef enum logic [1:0] {
        IRP_LVL_OFF  = 2'b00,
        IRP_LVL_LOW  = 2'b01,
        IRP_LVL_NOM  = 2'b10,
        IRP_LVL_HIGH = 2'b11
    } irp_level_t;

    // vector presenter state
    typedef enum logic {
        IRP_IDLE = 1'b0,
        IRP_WAIT = 1'b1
    } irp_state_t;

    // vectored request toward the core
    typedef struct packed {
        logic       valid;
        logic [3:0] src;
        irp_level_t level;
    } irp_vec_t;

    // register port request
    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [`IRP_AW-1:0]    addr;
        logic [7:0]            wdata;
    } irp_bus_t;

endpackage : irp_pkg

// >>> hw/irp_ctrl.sv
/*
 * irp_ctrl: port C request latch, group-0 enable/priority pair and
 * vectored request presenter with a small event interrupt.
 * assumes: one clock clk_sys, synchronous active-low reset, a register
 * master on the same clock, port C pins asynchronous, group-0 pending
 * bits and the group-2 enable pairs from logic on the same clock.
 */
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "irp_defines.svh"

module irp_ctrl #(
    parameter int ADDR_W = `IRP_AW          // register address width
) (
    input  wire logic             clk_sys,         // system clock
    input  wire logic             rstn,            // sync reset, low
    input  wire irp_pkg::irp_bus_t bus,            // register request
    output logic [7:0]            rdata,           // read data, next cycle
    input  wire logic [3:0]       portcPin,        // port C requests, async
    input  wire logic [7:0]       group0Pending,   // group-0 latch bits
    input  wire logic [3:0]       group2EnHigh,    // port C enable high
    input  wire logic [3:0]       group2EnLow,     // port C enable low
    input  wire logic             globalIrqEnable, // core global enable
    output irp_pkg::irp_vec_t     vecOut,          // vectored request
    input  wire logic             vecAck,          // core acknowledge
    output logic [7:0]            group0Clear,     // group-0 clear pulse
    output logic                  irqOut           // event interrupt
);
    import irp_pkg::*;

    //------------------------------------------------------------
    // declarations
    //------------------------------------------------------------
    logic [3:0]          portcMeta;
    logic [3:0]          portcSync;
    logic [3:0]          portcPrev;
    logic [3:0]          portcRise;
    logic [3:0]          group2Req;
    logic [7:0]          group0EnHigh;
    logic [7:0]          group0EnLow;
    logic [`IRP_ST_W-1:0] stat;
    logic [`IRP_ST_W-1:0] mask;
    logic [`IRP_ST_W-1:0] statEvent;
    logic [`IRP_ST_W-1:0] statClr;
    irp_level_t          candLvl [`IRP_NSRC];
    irp_vec_t            best;
    logic                bestOk;
    irp_state_t          state;
    logic                ackTake;
    logic [3:0]          ackG2Mask;
    logic                wrG0EH;
    logic                wrG0EL;
    logic                wrG2RQ;
    logic                wrStat;
    logic                wrMask;

    // group-0 slots that exist; a literal cannot be bit-selected directly
    localparam logic [7:0] G0_SRC = `IRP_G0_SRC;

    // write decode
    assign wrG0EH = bus.wr && (bus.addr == `IRP_OFS_G0EH);
    assign wrG0EL = bus.wr && (bus.addr == `IRP_OFS_G0EL);
    assign wrG2RQ = bus.wr && (bus.addr == `IRP_OFS_G2RQ);
    assign wrStat = bus.wr && (bus.addr == `IRP_OFS_STAT);
    assign wrMask = bus.wr && (bus.addr == `IRP_OFS_MASK);

    //------------------------------------------------------------
    // port C synchroniser and arrival detect
    //------------------------------------------------------------
    // two flops, then a previous-value flop for the edge
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            portcMeta <= `IRP_RST4;
            portcSync <= `IRP_RST4;
            portcPrev <= `IRP_RST4;
        end else begin
            portcMeta <= portcPin;
            portcSync <= portcMeta;
            portcPrev <= portcSync;
        end
    end

    // a request is presented on the rising edge
    assign portcRise = portcSync & ~portcPrev;

    //------------------------------------------------------------
    // acknowledge of the presented vector
    //------------------------------------------------------------
    // only an ack against a standing vector counts
    assign ackTake = vecAck && vecOut.valid;

    // one-hot of the port C bit to clear on ack
    always_comb begin
        ackG2Mask = `IRP_RST4;
        if (ackTake && (vecOut.src >= 4'(`IRP_G2_BASE))) begin
            ackG2Mask[2'(vecOut.src - 4'(`IRP_G2_BASE))] = 1'b1;
        end
    end

    //------------------------------------------------------------
    // group-2 request latch
    //------------------------------------------------------------
    // software write, ack clear, hardware set; any set beats a same-cycle ack
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            group2Req <= `IRP_RST4;
        end else if (wrG2RQ) begin
            group2Req <= bus.wdata[3:0] | portcRise;
        end else begin
            group2Req <= (group2Req & ~ackG2Mask) | portcRise;
        end
    end

    //------------------------------------------------------------
    // group-0 enable pair
    //------------------------------------------------------------
    // enable-high keeps all bits as written
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            group0EnHigh <= `IRP_RST8;
        end else if (wrG0EH) begin
            group0EnHigh <= bus.wdata;
        end
    end

    // enable-low stores the source bits only
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            group0EnLow <= `IRP_RST8;
        end else if (wrG0EL) begin
            group0EnLow <= bus.wdata & `IRP_G0_SRC;
        end
    end

    //------------------------------------------------------------
    // per-source level decode
    //------------------------------------------------------------
    // slots 0..7 are group-0 positions, 8..11 are port C pins
    // a group-0 bit under its clear pulse is stale and must not be picked again
    for (genvar i = 0; i < `IRP_NSRC; i++) begin : gSrc
        if (i < `IRP_G2_BASE) begin : gG0
            assign candLvl[i] = (group0Pending[i] && !group0Clear[i] && G0_SRC[i])
                ? irp_level_t'({group0EnHigh[i], group0EnLow[i]})
                : IRP_LVL_OFF;
        end else begin : gG2
            assign candLvl[i] = group2Req[i - `IRP_G2_BASE]
                ? irp_level_t'({group2EnHigh[i - `IRP_G2_BASE],
                                group2EnLow[i - `IRP_G2_BASE]})
                : IRP_LVL_OFF;
        end
    end

    //------------------------------------------------------------
    // priority pick
    //------------------------------------------------------------
    // highest level wins, ties go to the lowest slot
    always_comb begin
        best = '0;
        for (int i = 0; i < `IRP_NSRC; i++) begin
            if (candLvl[i] > best.level) begin
                best.valid = 1'b1;
                best.src   = 4'(i);
                best.level = candLvl[i];
            end
        end
    end

    // no pending level above the pick, for checking only
    always_comb begin
        bestOk = 1'b1;
        for (int i = 0; i < `IRP_NSRC; i++) begin
            if (candLvl[i] > best.level) begin
                bestOk = 1'b0;
            end
        end
    end

    //------------------------------------------------------------
    // vector presenter
    //------------------------------------------------------------
    // hold a pick until ack, withdraw on global disable
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state  <= IRP_IDLE;
            vecOut <= '0;
        end else begin
            unique case (state)
                IRP_IDLE: begin
                    if (globalIrqEnable && best.valid) begin
                        state  <= IRP_WAIT;
                        vecOut <= best;
                    end
                end
                IRP_WAIT: begin
                    if (ackTake || !globalIrqEnable) begin
                        state        <= IRP_IDLE;
                        vecOut.valid <= 1'b0;
                    end
                end
            endcase
        end
    end

    // group-0 latch lives outside; send it a clear pulse
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            group0Clear <= `IRP_RST8;
        end else begin
            group0Clear <= `IRP_RST8;
            if (ackTake && (vecOut.src < 4'(`IRP_G2_BASE))) begin
                group0Clear[3'(vecOut.src)] <= 1'b1;
            end
        end
    end

    //------------------------------------------------------------
    // event status, mask and interrupt
    //------------------------------------------------------------
    // events: port C arrival, ack taken, software-made request
    always_comb begin
        statEvent = `IRP_RST3;
        statEvent[`IRP_ST_HWREQ] = |portcRise;
        statEvent[`IRP_ST_ACK]   = ackTake;
        statEvent[`IRP_ST_SWREQ] = wrG2RQ && |(bus.wdata[3:0] & ~group2Req);
        statClr = wrStat ? bus.wdata[`IRP_ST_W-1:0] : `IRP_RST3;
    end

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            stat <= `IRP_RST3;
        end else begin
            stat <= (stat & ~statClr) | statEvent;
        end
    end

    // mask register, same layout as status
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mask <= `IRP_RST3;
        end else if (wrMask) begin
            mask <= bus.wdata[`IRP_ST_W-1:0];
        end
    end

    // level interrupt while an unmasked status bit stands
    assign irqOut = |(stat & mask);

    //------------------------------------------------------------
    // register read
    //------------------------------------------------------------
    // data stands in the cycle after the strobe only
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rdata <= `IRP_RST8;
        end else if (bus.rd) begin
            unique case (bus.addr)
                `IRP_OFS_G0EH: rdata <= group0EnHigh;
                `IRP_OFS_G0EL: rdata <= group0EnLow;
                `IRP_OFS_G2RQ: rdata <= {4'h0, group2Req};
                `IRP_OFS_STAT: rdata <= {5'h00, stat};
                `IRP_OFS_MASK: rdata <= {5'h00, mask};
                default:       rdata <= `IRP_RST8;
            endcase
        end else begin
            rdata <= `IRP_RST8;
        end
    end

    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // idle with an enabled pick under global enable
    sequence sPick;
        state == IRP_IDLE && globalIrqEnable && best.valid;
    endsequence

    // ack against a standing port C vector
    sequence sAckG2;
        ackTake && (vecOut.src >= 4'(`IRP_G2_BASE));
    endsequence

    AST_LATCH_SET: assert property (
        (portcRise != 4'h0)
        |=> ((group2Req & $past(portcRise)) == $past(portcRise)))
        else $error("arrived port C request not latched");

    AST_LATCH_HOLD: assert property (
        (group2Req != 4'h0) && !wrG2RQ && !ackTake
        |=> ((group2Req & $past(group2Req)) == $past(group2Req)))
        else $error("pending request lost without clear");

    AST_VEC_EN: assert property (
        sPick |=> vecOut.valid && vecOut.src == $past(best.src))
        else $error("pending request not vectored");

    AST_NO_VEC_DIS: assert property (
        !globalIrqEnable |=> !vecOut.valid)
        else $error("vector presented while globally disabled");

    AST_POLL_READ: assert property (
        bus.rd && bus.addr == `IRP_OFS_G2RQ
        |=> rdata == {4'h0, $past(group2Req)})
        else $error("request latch read mismatch");

    AST_LEVEL: assert property (
        sPick |=> vecOut.level != IRP_LVL_OFF
                  && vecOut.level == $past(candLvl[best.src]))
        else $error("vector level not the decoded pair");

    AST_G0_MAP: assert property (
        vecOut.valid && vecOut.src < 4'(`IRP_G2_BASE)
        |-> G0_SRC[3'(vecOut.src)])
        else $error("vector from a reserved group-0 slot");

    AST_ENL_RESV: assert property (
        bus.rd && bus.addr == `IRP_OFS_G0EL
        |=> (rdata & ~`IRP_G0_SRC) == 8'h00)
        else $error("reserved enable-low bit reads nonzero");

    AST_ACK_CLR: assert property (
        sAckG2 ##0 !wrG2RQ
        |=> (group2Req & $past(ackG2Mask) & ~$past(portcRise)) == 4'h0)
        else $error("acknowledged request not cleared");

    AST_SW_SET: assert property (
        wrG2RQ |=> (group2Req & $past(bus.wdata[3:0]))
                   == $past(bus.wdata[3:0]))
        else $error("software request not latched");

    AST_PRIO: assert property (
        best.valid |-> bestOk)
        else $error("lower level picked over a higher one");

endmodule : irp_ctrl

// >>> test/irp_core_model.sv
/*
 * irp_core_model: behavioural processor core taking vectored requests.
 * assumes: irp_pkg compiled first; same clock and reset as the controller.
 */
`timescale 1ns/1ps

module irp_core_model
    import irp_pkg::*;
(
    input  wire logic              clk_sys,  // system clock
    input  wire logic              rstn,     // sync reset, low
    input  wire irp_pkg::irp_vec_t vecOut,   // request from controller
    input  wire logic [7:0]        ackDelay, // cycles before acknowledge
    output logic                   vecAck    // one-cycle acknowledge
);
    // ---------------------------------------------------------------
    // acknowledge
    // ---------------------------------------------------------------
    logic [7:0] waitCnt; // cycles the request has stood

    // ack a standing request after ackDelay cycles, one pulse per request
    always @(posedge clk_sys) begin
        if (!rstn) begin
            vecAck  <= 1'b0;
            waitCnt <= 8'h00;
        end else if (vecAck) begin
            vecAck  <= 1'b0;
            waitCnt <= 8'h00;
        end else if (vecOut.valid && waitCnt >= ackDelay) begin
            vecAck <= 1'b1;
        end else if (vecOut.valid) begin
            waitCnt <= waitCnt + 8'h01;
        end else begin
            waitCnt <= 8'h00; // dropped request restarts the wait
        end
    end
endmodule : irp_core_model

// >>> test/irp_ctrl_tb.sv
/*
 * irp_ctrl_tb: register, polling, priority and acknowledge tests.
 * assumes: irp_pkg, irp_defines.svh, irp_ctrl and irp_core_model present.
 */
`timescale 1ns/1ps
`include "irp_defines.svh"

// compare, count and report one value
`define CHK(what, expv, gotv) \
    begin compares++; if ((gotv) !== (expv)) begin errors++; \
    $display("FAIL %s expected %h seen %h", what, expv, gotv); end end

module irp_ctrl_tb;
    import irp_pkg::*;

    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic       clk_sys = 1'b0;
    logic       rstn;
    irp_bus_t   bus;
    logic [7:0] rdata;
    logic [3:0] portcPin;
    logic [7:0] group0Pending;
    logic [3:0] group2EnHigh;
    logic [3:0] group2EnLow;
    logic       globalIrqEnable;
    irp_vec_t   vecOut;
    logic       vecAck;
    logic [7:0] group0Clear;
    logic       irqOut;
    logic [7:0] ackDelay;
    logic [7:0] rd;
    int         errors;
    int         compares;
    int         cycles;
    int         k;
    irp_vec_t   taken[$];
    logic [3:0] expSrc[3] = '{4'h9, 4'ha, 4'h8};
    irp_level_t expLvl[3] = '{IRP_LVL_HIGH, IRP_LVL_NOM, IRP_LVL_LOW};

    irp_ctrl dut (.clk_sys(clk_sys), .rstn(rstn), .bus(bus), .rdata(rdata), .portcPin(portcPin),
                  .group0Pending(group0Pending), .group2EnHigh(group2EnHigh), .group2EnLow(group2EnLow),
                  .globalIrqEnable(globalIrqEnable), .vecOut(vecOut), .vecAck(vecAck),
                  .group0Clear(group0Clear), .irqOut(irqOut));
    irp_core_model core (.clk_sys(clk_sys), .rstn(rstn), .vecOut(vecOut), .ackDelay(ackDelay),
                         .vecAck(vecAck));

    // clock, acknowledged request log, group-0 source clearing, hang limit
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (vecAck && vecOut.valid) taken.push_back(vecOut);
        if (rstn && |group0Clear) group0Pending <= group0Pending & ~group0Clear;
        cycles++;
        if (cycles == 5000) begin
            errors++;
            stop_test();
        end
    end

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        bus <= '0;
    endtask : reg_wr

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        bus <= '0;
        #1 rd = rdata;
        `CHK(what, e, rd)
    endtask : rd_chk

    task automatic wait_taken(input int n);
        int i;
        i = 0;
        while (taken.size() < n && i < 200) begin
            @(posedge clk_sys);
            i++;
        end
        @(posedge clk_sys);
        #1 `CHK("acks", n, taken.size())
    endtask : wait_taken

    task automatic stop_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        rstn = 1'b0; bus = '0; portcPin = 4'h0; group0Pending = 8'h00; ackDelay = 8'h00;
        group2EnHigh = 4'h0; group2EnLow = 4'h0; globalIrqEnable = 1'b0;
        errors = 0; compares = 0; cycles = 0;
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd_chk("g0eh reset", `IRP_OFS_G0EH, 8'h00);
        rd_chk("g0el reset", `IRP_OFS_G0EL, 8'h00);
        rd_chk("latch reset", `IRP_OFS_G2RQ, 8'h00);
        reg_wr(`IRP_OFS_G0EH, 8'hff);
        rd_chk("g0eh rw", `IRP_OFS_G0EH, 8'hff);
        reg_wr(`IRP_OFS_G0EL, 8'hff);
        rd_chk("g0el reserved", `IRP_OFS_G0EL, 8'h79);
        rd_chk("unmapped", 12'h000, 8'h00);
        // pin0 level 1, pin1 level 3, pin2 level 2, pin3 off; set all by software, polled
        group2EnHigh <= 4'b0110;
        group2EnLow  <= 4'b0011;
        reg_wr(`IRP_OFS_G2RQ, 8'h0f);
        rd_chk("latch sw set", `IRP_OFS_G2RQ, 8'h0f);
        repeat (10) @(posedge clk_sys);
        #1 `CHK("polled no vector", 1'b0, vecOut.valid)
        // vectored, prompt core: highest level first, acks clear bits
        globalIrqEnable <= 1'b1;
        wait_taken(3);
        for (k = 0; k < 3; k++) begin
            `CHK("prio src", expSrc[k], taken[k].src)
            `CHK("prio level", expLvl[k], taken[k].level)
        end
        rd_chk("latch after acks", `IRP_OFS_G2RQ, 8'h08);
        globalIrqEnable <= 1'b0;
        // group 0: timer1 level 2, converter level 1, timer0 off, slow core
        reg_wr(`IRP_OFS_G0EH, 8'h40);
        reg_wr(`IRP_OFS_G0EL, 8'h01);
        taken.delete();
        group0Pending <= 8'h63;
        ackDelay <= 8'h03;
        globalIrqEnable <= 1'b1;
        wait_taken(2);
        `CHK("g0 first", {4'h6, IRP_LVL_NOM}, {taken[0].src, taken[0].level})
        `CHK("g0 second", {4'h0, IRP_LVL_LOW}, {taken[1].src, taken[1].level})
        `CHK("g0 cleared", 8'h22, group0Pending)
        globalIrqEnable <= 1'b0;
        // hardware arrival latches and holds; status and mask drive irqOut
        reg_wr(`IRP_OFS_STAT, 8'h07);
        rd_chk("status clear", `IRP_OFS_STAT, 8'h00);
        portcPin <= 4'h4;
        repeat (2) @(posedge clk_sys);
        portcPin <= 4'h0;
        repeat (4) @(posedge clk_sys);
        rd_chk("latch hw", `IRP_OFS_G2RQ, 8'h0c);
        rd_chk("status arrival", `IRP_OFS_STAT, 8'h01);
        `CHK("irq masked", 1'b0, irqOut)
        reg_wr(`IRP_OFS_MASK, 8'h01);
        #1 `CHK("irq unmasked", 1'b1, irqOut)
        reg_wr(`IRP_OFS_STAT, 8'h01);
        #1 `CHK("irq cleared", 1'b0, irqOut)
        // global disable withdraws a standing request without clearing it
        reg_wr(`IRP_OFS_G2RQ, 8'h01);
        ackDelay <= 8'd50;
        globalIrqEnable <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 `CHK("standing", {1'b1, 4'h8}, {vecOut.valid, vecOut.src})
        globalIrqEnable <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 `CHK("withdrawn", 1'b0, vecOut.valid)
        rd_chk("latch kept", `IRP_OFS_G2RQ, 8'h01);
        taken.delete();
        ackDelay <= 8'h00;
        globalIrqEnable <= 1'b1;
        wait_taken(1);
        `CHK("resumed src", 4'h8, taken[0].src)
        rd_chk("latch final", `IRP_OFS_G2RQ, 8'h00);
        rd_chk("status events", `IRP_OFS_STAT, 8'h06);
        stop_test();
    end
endmodule : irp_ctrl_tb
